// *** include/dual_conv_pkg.sv ***
// shared constants and types of the dual converter input interface
`default_nettype none
package dual_conv_pkg;
	localparam int CODE_W = 14;
	localparam logic [13:0] CODE_MAX = 14'h3fff;
	localparam int IREF_W = 16;
	localparam int FS_SHIFT = 5;
	localparam int FS_W = 21;
	localparam int LAT_STAGES = 4;
	localparam int FIFO_DEPTH = 16;
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] IREF_A_OFF = 8'h08;
	localparam logic [7:0] IREF_B_OFF = 8'h0c;
	localparam logic [7:0] FS_A_OFF = 8'h10;
	localparam logic [7:0] FS_B_OFF = 8'h14;
	localparam logic [7:0] CODE_A_OFF = 8'h18;
	localparam logic [7:0] CODE_B_OFF = 8'h1c;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [15:0] IREF_RESET = 16'h0000;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [13:0] code_a;
		logic [13:0] code_b;
	} sample_pair_t;

	typedef enum logic [1:0] {
		MODE_INTERLEAVED = 2'b01,
		MODE_DUAL = 2'b10
	} bus_mode_t;
endpackage
`default_nettype wire

// *** rtl/dual_conv_input.sv ***
// input latches, interleave steering, latch clock divider, register slave and sample fifo
`default_nettype none

// ----------------------------------------
// sample fifo
// ----------------------------------------
module sample_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (PW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg];
	assign level = count_reg;

	always_ff @(posedge aclk) begin
		if (ce && push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (ce) begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------
// converter input interface
// ----------------------------------------
module dual_conv_input (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic bus_mode,
	input wire logic [13:0] bus_a,
	input wire logic [13:0] bus_b,
	input wire logic write_strobe_a,
	input wire logic write_strobe_b,
	input wire logic update_clock_a,
	input wire logic update_clock_b,
	input wire logic channel_select,
	input wire logic pairing_reset,
	input wire logic gain_select,
	output logic divided_latch_clock,
	output logic [13:0] primary_current_out_a,
	output logic [13:0] complement_current_out_a,
	output logic [13:0] primary_current_out_b,
	output logic [13:0] complement_current_out_b,
	output logic [20:0] full_scale_a,
	output logic [20:0] full_scale_b,
	output logic input_ready,
	output logic sample_valid,
	input wire logic sample_ready,
	output dual_conv_pkg::sample_pair_t sample_data,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [20:0] scale_ref(input logic [15:0] iref);
		return 21'(iref) << dual_conv_pkg::FS_SHIFT;
	endfunction

	function automatic logic rise(input logic now_v, input logic prev_v);
		return now_v && !prev_v;
	endfunction

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [31:0] ctrl_reg;
	logic [15:0] iref_a_reg;
	logic [15:0] iref_b_reg;
	logic wa_prev_reg, wb_prev_reg, ca_prev_reg, cb_prev_reg;
	logic [13:0] in_a_reg, in_b_reg;
	logic [13:0] pres_a_reg, pres_b_reg;
	logic [13:0] pipe_a_reg [dual_conv_pkg::LAT_STAGES];
	logic [13:0] pipe_b_reg [dual_conv_pkg::LAT_STAGES];
	logic div_reg;
	logic div_next;
	dual_conv_pkg::bus_mode_t mode;
	logic enabled;
	logic wr_a_rise, wr_b_rise, wr_a_fall, clk_a_rise, clk_b_rise;
	logic adv_a, adv_b;
	logic fifo_ready;
	logic [4:0] fifo_level;
	dual_conv_pkg::sample_pair_t push_pair;

	// bus mode selection
	// mode pin decode
	assign mode = bus_mode ? dual_conv_pkg::MODE_DUAL : dual_conv_pkg::MODE_INTERLEAVED;
	assign enabled = ctrl_reg[dual_conv_pkg::CTRL_EN_BIT];
	assign wr_a_rise = enabled && rise(write_strobe_a, wa_prev_reg);
	assign wr_b_rise = enabled && rise(write_strobe_b, wb_prev_reg);
	assign wr_a_fall = enabled && rise(wa_prev_reg, write_strobe_a);
	assign clk_a_rise = enabled && rise(update_clock_a, ca_prev_reg);
	assign clk_b_rise = enabled && rise(update_clock_b, cb_prev_reg);

	always_comb begin
		div_next = div_reg;
		if (pairing_reset) begin
			div_next = 1'b0;
		end else if (clk_a_rise) begin
			div_next = !div_reg;
		end
	end

	// converter advance, stalled while the fifo is full
	always_comb begin
		adv_a = 1'b0;
		adv_b = 1'b0;
		case (mode)
			dual_conv_pkg::MODE_DUAL: begin
				adv_a = clk_a_rise && fifo_ready;
				adv_b = clk_b_rise && fifo_ready;
			end
			dual_conv_pkg::MODE_INTERLEAVED: begin
				adv_a = !div_reg && div_next && fifo_ready;
				adv_b = adv_a;
			end
			default: begin
				adv_a = 1'b0;
				adv_b = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// pin edge tracking
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wa_prev_reg <= 1'b0;
			wb_prev_reg <= 1'b0;
			ca_prev_reg <= 1'b0;
			cb_prev_reg <= 1'b0;
		end else if (ce) begin
			wa_prev_reg <= write_strobe_a;
			wb_prev_reg <= write_strobe_b;
			ca_prev_reg <= update_clock_a;
			cb_prev_reg <= update_clock_b;
		end
	end

	// ----------------------------------------
	// input latches
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_a_reg <= '0;
			in_b_reg <= '0;
		end else if (ce) begin
			if (mode == dual_conv_pkg::MODE_DUAL) begin
				if (wr_a_rise) begin
					in_a_reg <= bus_a;
				end
				if (wr_b_rise) begin
					in_b_reg <= bus_b;
				end
			end else if (wr_a_rise) begin
				if (channel_select) begin
					in_a_reg <= bus_a;
					in_b_reg <= in_b_reg;
				end else begin
					in_b_reg <= bus_a;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pres_a_reg <= '0;
			pres_b_reg <= '0;
		end else if (ce && mode == dual_conv_pkg::MODE_INTERLEAVED && wr_a_fall) begin
			pres_a_reg <= in_a_reg;
			pres_b_reg <= in_b_reg;
		end
	end

	// divider held low under pairing reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 1'b0;
		end else if (ce) begin
			div_reg <= (mode == dual_conv_pkg::MODE_INTERLEAVED) ? div_next : 1'b0;
		end
	end
	assign divided_latch_clock = div_reg;

	// ----------------------------------------
	// converter latch and latency pipeline
	// ----------------------------------------
	// converter latch loads on update
	// four update stages to the output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < dual_conv_pkg::LAT_STAGES; i++) begin
				pipe_a_reg[i] <= '0;
				pipe_b_reg[i] <= '0;
			end
		end else if (ce) begin
			if (adv_a) begin
				pipe_a_reg[0] <= (mode == dual_conv_pkg::MODE_DUAL) ? in_a_reg : pres_a_reg;
				for (int i = 1; i < dual_conv_pkg::LAT_STAGES; i++) begin
					pipe_a_reg[i] <= pipe_a_reg[i-1];
				end
			end
			if (adv_b) begin
				pipe_b_reg[0] <= (mode == dual_conv_pkg::MODE_DUAL) ? in_b_reg : pres_b_reg;
				for (int i = 1; i < dual_conv_pkg::LAT_STAGES; i++) begin
					pipe_b_reg[i] <= pipe_b_reg[i-1];
				end
			end
		end
	end

	// ----------------------------------------
	// output codes and full scale
	// ----------------------------------------
	// offset binary used directly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			primary_current_out_a <= '0;
			complement_current_out_a <= dual_conv_pkg::CODE_MAX;
			primary_current_out_b <= '0;
			complement_current_out_b <= dual_conv_pkg::CODE_MAX;
		end else if (ce) begin
			primary_current_out_a <= pipe_a_reg[dual_conv_pkg::LAT_STAGES-1];
			complement_current_out_a <= dual_conv_pkg::CODE_MAX
				- pipe_a_reg[dual_conv_pkg::LAT_STAGES-1];
			primary_current_out_b <= pipe_b_reg[dual_conv_pkg::LAT_STAGES-1];
			complement_current_out_b <= dual_conv_pkg::CODE_MAX
				- pipe_b_reg[dual_conv_pkg::LAT_STAGES-1];
		end
	end

	// full scale is reference times 32
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_scale_a <= '0;
			full_scale_b <= '0;
		end else if (ce) begin
			full_scale_a <= scale_ref(iref_a_reg);
			full_scale_b <= gain_select ? scale_ref(iref_a_reg) : scale_ref(iref_b_reg);
		end
	end

	// ----------------------------------------
	// sample fifo
	// ----------------------------------------
	assign push_pair.code_a = (mode == dual_conv_pkg::MODE_DUAL) ? in_a_reg : pres_a_reg;
	assign push_pair.code_b = (mode == dual_conv_pkg::MODE_DUAL) ? in_b_reg : pres_b_reg;
	assign input_ready = fifo_ready;

	sample_fifo #(
		.WIDTH($bits(dual_conv_pkg::sample_pair_t)),
		.DEPTH(dual_conv_pkg::FIFO_DEPTH)
	) fifo_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.in_valid(adv_a || adv_b),
		.in_ready(fifo_ready),
		.in_data(push_pair),
		.out_valid(sample_valid),
		.out_ready(sample_ready),
		.out_data(sample_data),
		.level(fifo_level)
	);

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic do_write;
	logic addr_ok;

	assign s_axi_awready = !aw_got_reg && !bvalid_reg;
	assign s_axi_wready = !w_got_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign do_write = aw_got_reg && w_got_reg;
	assign addr_ok = awaddr_reg == dual_conv_pkg::CTRL_OFF
		|| awaddr_reg == dual_conv_pkg::IREF_A_OFF
		|| awaddr_reg == dual_conv_pkg::IREF_B_OFF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= dual_conv_pkg::RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= addr_ok ? dual_conv_pkg::RESP_OKAY : dual_conv_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= dual_conv_pkg::CTRL_RESET;
			iref_a_reg <= dual_conv_pkg::IREF_RESET;
			iref_b_reg <= dual_conv_pkg::IREF_RESET;
		end else if (ce && do_write) begin
			case (awaddr_reg)
				dual_conv_pkg::CTRL_OFF: begin
					ctrl_reg <= merge_bytes(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0001;
				end
				dual_conv_pkg::IREF_A_OFF: begin
					iref_a_reg <= 16'(merge_bytes({16'h0000, iref_a_reg}, wdata_reg, wstrb_reg));
				end
				dual_conv_pkg::IREF_B_OFF: begin
					iref_b_reg <= 16'(merge_bytes({16'h0000, iref_b_reg}, wdata_reg, wstrb_reg));
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= dual_conv_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= dual_conv_pkg::RESP_OKAY;
				case (s_axi_araddr)
					dual_conv_pkg::CTRL_OFF: rdata_reg <= ctrl_reg;
					dual_conv_pkg::STATUS_OFF: begin
						rdata_reg <= {22'h000000, fifo_level, fifo_ready, div_reg,
							pairing_reset, gain_select, bus_mode};
					end
					dual_conv_pkg::IREF_A_OFF: rdata_reg <= {16'h0000, iref_a_reg};
					dual_conv_pkg::IREF_B_OFF: rdata_reg <= {16'h0000, iref_b_reg};
					dual_conv_pkg::FS_A_OFF: rdata_reg <= {11'h000, full_scale_a};
					dual_conv_pkg::FS_B_OFF: rdata_reg <= {11'h000, full_scale_b};
					dual_conv_pkg::CODE_A_OFF: rdata_reg <= {18'h00000, primary_current_out_a};
					dual_conv_pkg::CODE_B_OFF: rdata_reg <= {18'h00000, primary_current_out_b};
					default: begin
						rdata_reg <= '0;
						rresp_reg <= dual_conv_pkg::RESP_SLVERR;
					end
				endcase
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** testbench/dual_conv_input_checker.sv ***
// port assertions of the converter input interface
`default_nettype none
module dual_conv_input_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic bus_mode,
	input wire logic pairing_reset,
	input wire logic gain_select,
	input wire logic divided_latch_clock,
	input wire logic [13:0] primary_current_out_a,
	input wire logic [13:0] complement_current_out_a,
	input wire logic [13:0] primary_current_out_b,
	input wire logic [13:0] complement_current_out_b,
	input wire logic [20:0] full_scale_a,
	input wire logic [20:0] full_scale_b,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire dual_conv_pkg::sample_pair_t sample_data,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_compl_sum: assert property (
		complement_current_out_a == dual_conv_pkg::CODE_MAX - primary_current_out_a &&
		complement_current_out_b == dual_conv_pkg::CODE_MAX - primary_current_out_b)
		else $error("complement output mismatch");
	a_fs_scale: assert property (
		full_scale_a[4:0] == 5'h00 && full_scale_b[4:0] == 5'h00)
		else $error("full scale not a multiple of 32");
	a_gain_shared: assert property (
		gain_select && $past(gain_select) && $past(ce) |-> full_scale_b == full_scale_a)
		else $error("shared gain not applied");
	a_pair_low: assert property (
		$past(pairing_reset) && $past(ce) |-> !divided_latch_clock)
		else $error("divided clock high in pairing reset");
	a_dual_low: assert property (
		bus_mode && $past(bus_mode) |-> !divided_latch_clock)
		else $error("divided clock high in dual mode");
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
	a_fifo_hold: assert property (
		sample_valid && !sample_ready |=> sample_valid && $stable(sample_data))
		else $error("stalled sample changed");
endmodule
bind dual_conv_input dual_conv_input_checker chk_u (
	.aclk, .aresetn, .ce, .bus_mode, .pairing_reset, .gain_select, .divided_latch_clock,
	.primary_current_out_a, .complement_current_out_a, .primary_current_out_b,
	.complement_current_out_b, .full_scale_a, .full_scale_b, .sample_valid, .sample_ready,
	.sample_data, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
`default_nettype wire

// *** testbench/dual_conv_input_tb_top.sv ***
// self-checking bench of the converter input interface
`default_nettype none
module dual_conv_input_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, ce, bus_mode, gain_select, sample_ready;
	logic [13:0] bus_a, bus_b;
	logic write_strobe_a, write_strobe_b, update_clock_a, update_clock_b;
	logic channel_select, pairing_reset, divided_latch_clock, input_ready, sample_valid;
	logic [13:0] primary_current_out_a, complement_current_out_a;
	logic [13:0] primary_current_out_b, complement_current_out_b;
	logic [20:0] full_scale_a, full_scale_b;
	dual_conv_pkg::sample_pair_t sample_data;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int miscompares = 0;
	int n_tests = 0;
	int div_rises = 0;
	logic div_q = 1'b0;
	dual_conv_input dut_u (.aclk, .aresetn, .ce, .bus_mode, .bus_a, .bus_b, .write_strobe_a,
		.write_strobe_b, .update_clock_a, .update_clock_b, .channel_select, .pairing_reset,
		.gain_select, .divided_latch_clock, .primary_current_out_a, .complement_current_out_a,
		.primary_current_out_b, .complement_current_out_b, .full_scale_a, .full_scale_b,
		.input_ready, .sample_valid, .sample_ready, .sample_data, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	host_model host_u (.aclk, .bus_a, .bus_b, .write_strobe_a, .write_strobe_b,
		.update_clock_a, .update_clock_b, .channel_select, .pairing_reset);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		div_q <= divided_latch_clock;
		if (divided_latch_clock && !div_q) div_rises <= div_rises + 1;
	end
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d of %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic hang;
		miscompares++;
		$display("unexpected handshake: expected answer seen none");
		stop_test();
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 100) hang();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 100) hang();
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		@(negedge aclk);
		chk("compl_a", complement_current_out_a, 32'h3fff);
		chk("input_ready", input_ready, 32'h1);
		chk("sample_valid", sample_valid, 32'h0);
		axi_read(dual_conv_pkg::CTRL_OFF, d, r);
		chk("ctrl", d, dual_conv_pkg::CTRL_RESET);
		axi_write(dual_conv_pkg::IREF_A_OFF, 32'h0000_1234, r);
		chk("wr_resp", r, dual_conv_pkg::RESP_OKAY);
		axi_write(dual_conv_pkg::IREF_B_OFF, 32'h0000_0100, r);
		axi_read(dual_conv_pkg::IREF_A_OFF, d, r);
		chk("iref_a", d, 32'h0000_1234);
		repeat (2) @(negedge aclk);
		chk("fs_a", full_scale_a, 32'h0002_4680);
		chk("fs_b", full_scale_b, 32'h0000_2000);
		axi_read(dual_conv_pkg::FS_A_OFF, d, r);
		chk("fs_a_reg", d, 32'h0002_4680);
		@(posedge aclk);
		gain_select <= 1'b1;
		repeat (3) @(negedge aclk);
		chk("fs_b", full_scale_b, 32'h0002_4680);
		axi_read(8'h40, d, r);
		chk("rd_resp", r, dual_conv_pkg::RESP_SLVERR);
		chk("rd_data", d, 32'h0);
		axi_write(8'h44, 32'hffff_ffff, r);
		chk("wr_resp", r, dual_conv_pkg::RESP_SLVERR);
	endtask
	task automatic t_dual;
		int n, k;
		host_u.wr(1'b0, 1'b1, 14'h2abc);
		host_u.wr(1'b1, 1'b1, 14'h1555);
		repeat (3) host_u.upd(2'b01);
		@(negedge aclk);
		chk("code_a", primary_current_out_a, 32'h0);
		host_u.upd(2'b01);
		@(negedge aclk);
		chk("code_a", primary_current_out_a, 32'h2abc);
		chk("code_b", primary_current_out_b, 32'h0);
		axi_read(dual_conv_pkg::CODE_A_OFF, d, r);
		chk("code_a_reg", d, 32'h0000_2abc);
		repeat (4) host_u.upd(2'b10);
		@(negedge aclk);
		chk("code_b", primary_current_out_b, 32'h1555);
		chk("compl_b", complement_current_out_b, 32'h2aaa);
		@(posedge aclk);
		ce <= 1'b0;
		host_u.upd(2'b10);
		ce <= 1'b1;
		@(posedge aclk);
		sample_ready <= 1'b1;
		n = 0;
		for (k = 0; k < 50 && n < 8; k++) begin
			@(posedge aclk);
			if (sample_valid) begin
				chk("dual_pair", sample_data, {14'h2abc, 14'h1555});
				n++;
			end
		end
		sample_ready <= 1'b0;
		chk("dual_pops", n, 32'd8);
		@(negedge aclk);
		chk("sample_valid", sample_valid, 32'h0);
	endtask
	task automatic t_inter;
		dual_conv_pkg::sample_pair_t q[$];
		logic [13:0] a, b;
		int r0, n, k;
		@(posedge aclk);
		bus_mode <= 1'b0;
		host_u.pair_reset();
		r0 = div_rises;
		for (int i = 0; i < 17; i++) begin
			a = 14'h0100 + 14'(i);
			host_u.wr(1'b0, 1'b1, a);
			if (i != 5) b = 14'h2200 + 14'(i);
			if (i != 5) host_u.wr(1'b0, 1'b0, b);
			host_u.upd(2'b01);
			host_u.upd(2'b01);
			if (i < 16) q.push_back({a, b});
			if (i == 15) begin
				@(negedge aclk);
				chk("div_rises", div_rises - r0, 32'd16);
				chk("input_ready", input_ready, 32'h0);
				axi_read(dual_conv_pkg::STATUS_OFF, d, r);
				chk("status", d, 32'h0000_0202);
			end
		end
		n = 0;
		for (k = 0; k < 200 && n < 16; k++) begin
			@(posedge aclk);
			if (sample_valid && sample_ready) begin
				chk("pair", sample_data, q.pop_front());
				n++;
			end
			sample_ready <= k[0];
		end
		chk("pops", n, 32'd16);
		@(negedge aclk);
		chk("sample_valid", sample_valid, 32'h0);
	endtask
	initial begin
		ce = 1'b1;
		aresetn = 1'b0;
		bus_mode = 1'b1;
		gain_select = 1'b0;
		sample_ready = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_dual();
		t_inter();
		stop_test();
	end
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
// host model driving sample words and strobes
`default_nettype none
module host_model (
	input wire logic aclk,
	output logic [13:0] bus_a,
	output logic [13:0] bus_b,
	output logic write_strobe_a,
	output logic write_strobe_b,
	output logic update_clock_a,
	output logic update_clock_b,
	output logic channel_select,
	output logic pairing_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_a = 14'h0000;
		bus_b = 14'h0000;
		write_strobe_a = 1'b0;
		write_strobe_b = 1'b0;
		update_clock_a = 1'b0;
		update_clock_b = 1'b0;
		channel_select = 1'b0;
		pairing_reset = 1'b0;
	end
	// word write, noise on unused bus
	task automatic wr(input logic ch, input logic sel, input logic [13:0] w);
		@(posedge aclk);
		channel_select <= sel;
		if (ch) begin
			bus_b <= w;
			write_strobe_b <= 1'b1;
		end else begin
			bus_a <= w;
			bus_b <= ~w;
			write_strobe_a <= 1'b1;
		end
		repeat (2) @(posedge aclk);
		write_strobe_a <= 1'b0;
		write_strobe_b <= 1'b0;
		repeat (2) @(posedge aclk);
		bus_a <= ~bus_a;
		bus_b <= ~bus_b;
	endtask
	// update apart from write, slow rate
	task automatic upd(input logic [1:0] m);
		@(posedge aclk);
		update_clock_a <= m[0];
		update_clock_b <= m[1];
		repeat (2) @(posedge aclk);
		update_clock_a <= 1'b0;
		update_clock_b <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic pair_reset;
		@(posedge aclk);
		pairing_reset <= 1'b1;
		repeat (2) @(posedge aclk);
		update_clock_a <= 1'b1;
		repeat (2) @(posedge aclk);
		update_clock_a <= 1'b0;
		pairing_reset <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask
endmodule
`default_nettype wire
